//--- src/io_map_pkg.sv
// Constants and types for the peripheral I/O space access map.
package io_map_pkg;

    // Address windows, as seen by the core.
    localparam logic [7:0] BIT_IO_MAX  = 8'h1F;
    localparam logic [7:0] IO_MAX      = 8'h3F;
    localparam logic [7:0] IO_DATA_OFS = 8'h20;
    localparam logic [7:0] EXT_LO      = 8'h60;
    localparam logic [7:0] EXT_HI      = 8'hFF;

    // Reserved data addresses inside the extended space.
    localparam logic [7:0] RSV_LO      = 8'h8C;
    localparam logic [7:0] RSV_HI      = 8'hAF;
    localparam logic [7:0] RSV_A       = 8'hB5;
    localparam logic [7:0] RSV_B       = 8'hB7;

    // I/O address of the register whose bits are write-one-to-clear flags.
    localparam logic [7:0] FLAG_IO     = 8'h16;

    localparam logic [7:0] REG_RST     = 8'h00;
    localparam logic [7:0] FLAG_RST    = 8'h00;
    localparam logic [7:0] FULL_MASK   = 8'hFF;
    localparam int         LOC_COUNT   = 224;

    // Core operations; the three get forms and the three put forms behave
    // alike here, they differ only in how the core forms the address.
    typedef enum logic [3:0] {
        OP_IO_READ,
        OP_IO_WRITE,
        OP_BIT_SET,
        OP_BIT_CLEAR,
        OP_SKIP_SET,
        OP_SKIP_CLEAR,
        OP_MEM_GET,
        OP_MEM_GET_DIRECT,
        OP_MEM_GET_DISPLACED,
        OP_MEM_PUT,
        OP_MEM_PUT_DIRECT,
        OP_MEM_PUT_DISPLACED
    } op_t;

endpackage

//--- src/io_reg_store.sv
// Register store for the data-space image of the peripheral I/O space.
`timescale 1ns/1ps
module io_reg_store
    import io_map_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // Access channel
    io_store_if.store       bus,
    // Flag events from peripheral logic, same clock
    input  wire logic [7:0] hw_flag_set,
    output logic      [7:0] flag_view
);

    localparam logic [7:0] FLAG_DATA = FLAG_IO + IO_DATA_OFS;

    logic [7:0] mem_q [LOC_COUNT];
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] clr_bits;
    logic [7:0] ofs;
    wire        below = bus.idx < IO_DATA_OFS;
    wire        rsv   = (bus.idx >= RSV_LO && bus.idx <= RSV_HI) ||
                        bus.idx == RSV_A || bus.idx == RSV_B;
    wire        is_flag = bus.idx == FLAG_DATA;

    assign ofs = bus.idx - IO_DATA_OFS;

    // Reserved locations read zero and absorb writes.
    assign bus.rdata = (below || rsv) ? 8'h00 :
                       is_flag ? flags_q : mem_q[ofs];

    genvar i;
    generate
        for (i = 0; i < LOC_COUNT; i++) begin : g_loc
            localparam logic [7:0] ADDR = 8'(i + 32);
            wire hit = bus.wr && !rsv && !below && bus.idx == ADDR &&
                       ADDR != FLAG_DATA;
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    mem_q[i] <= REG_RST;
                end else if (ce && hit) begin
                    mem_q[i] <= (mem_q[i] & ~bus.wmask) |
                                (bus.wdata & bus.wmask);
                end
            end
        end
    endgenerate

    // Only bits both selected and written as one are cleared; a flag
    // raised in the same cycle survives the clear.
    assign clr_bits = (bus.wr && is_flag) ? (bus.wmask & bus.wdata) : 8'h00;
    assign flags_d  = (flags_q & ~clr_bits) | hw_flag_set;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags_q <= FLAG_RST;
        end else if (ce) begin
            flags_q <= flags_d;
        end
    end

    assign flag_view = flags_q;

endmodule // io_reg_store

//--- src/io_space_access_map.sv
// Peripheral I/O space access map: decodes core operations onto the store.
`timescale 1ns/1ps
module io_space_access_map
    import io_map_pkg::*;
(
    // Clock, reset and enable
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // Request from the core
    input  wire logic       req_valid,
    input  wire op_t        req_op,
    input  wire logic [7:0] req_addr,
    input  wire logic [2:0] req_bit,
    input  wire logic [7:0] req_wdata,
    // Answer to the core
    output logic            ans_valid,
    output logic      [7:0] ans_data,
    output logic            ans_skip,
    output logic            ans_fault,
    // Peripheral flag events and flag state
    input  wire logic [7:0] hw_flag_set,
    output logic      [7:0] flag_view
);

    io_store_if st ();

    logic       ans_valid_q;
    logic       ans_valid_d;
    logic [7:0] ans_data_q;
    logic [7:0] ans_data_d;
    logic       ans_skip_q;
    logic       ans_skip_d;
    logic       ans_fault_q;
    logic       ans_fault_d;

    // Operation classes.
    wire is_io_rd  = req_op == OP_IO_READ;
    wire is_io_wr  = req_op == OP_IO_WRITE;
    wire is_bset   = req_op == OP_BIT_SET;
    wire is_bclr   = req_op == OP_BIT_CLEAR;
    wire is_sks    = req_op == OP_SKIP_SET;
    wire is_skc    = req_op == OP_SKIP_CLEAR;
    wire is_get    = req_op == OP_MEM_GET || req_op == OP_MEM_GET_DIRECT ||
                     req_op == OP_MEM_GET_DISPLACED;
    wire is_put    = req_op == OP_MEM_PUT || req_op == OP_MEM_PUT_DIRECT ||
                     req_op == OP_MEM_PUT_DISPLACED;
    wire is_bit_op = is_bset || is_bclr || is_sks || is_skc;
    wire is_io_op  = is_io_rd || is_io_wr || is_bit_op;
    wire is_mem_op = is_get || is_put;

    // Range checks per operation class.
    wire bit_ok  = req_addr <= BIT_IO_MAX;
    wire io_ok   = req_addr <= IO_MAX;
    wire mem_ok  = req_addr >= IO_DATA_OFS;
    wire fault   = (is_bit_op && !bit_ok) || (is_io_op && !io_ok) ||
                   (is_mem_op && !mem_ok) || !(is_io_op || is_mem_op);

    // I/O operations land at their address plus the data-space offset.
    wire [7:0] io_data_addr = {2'b00, req_addr[5:0]} + IO_DATA_OFS;
    wire [7:0] bit_mask     = 8'h01 << req_bit;

    assign st.idx = is_io_op ? io_data_addr : req_addr;

    // Writes: a bit operation touches only the addressed bit.
    assign st.wr    = req_valid && ce && !fault &&
                      (is_io_wr || is_put || is_bset || is_bclr);
    assign st.wmask = (is_bset || is_bclr) ? bit_mask : FULL_MASK;
    assign st.wdata = is_bset ? bit_mask :
                      is_bclr ? 8'h00 : req_wdata;

    // Single-bit test for the skip decision.
    wire sel_bit = st.rdata[req_bit];

    assign ans_valid_d = req_valid;
    assign ans_fault_d = req_valid && fault;
    assign ans_data_d  = (req_valid && !fault && (is_io_rd || is_get)) ?
                         st.rdata : 8'h00;
    assign ans_skip_d  = req_valid && !fault &&
                         ((is_sks && sel_bit) || (is_skc && !sel_bit));

    io_reg_store u_store (
        .clk         (clk),
        .rst_n       (rst_n),
        .ce          (ce),
        .bus         (st.store),
        .hw_flag_set (hw_flag_set),
        .flag_view   (flag_view)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ans_valid_q <= 1'b0;
            ans_fault_q <= 1'b0;
            ans_skip_q  <= 1'b0;
            ans_data_q  <= REG_RST;
        end else if (ce) begin
            ans_valid_q <= ans_valid_d;
            ans_fault_q <= ans_fault_d;
            ans_skip_q  <= ans_skip_d;
            ans_data_q  <= ans_data_d;
        end
    end

    assign ans_valid = ans_valid_q;
    assign ans_data  = ans_data_q;
    assign ans_skip  = ans_skip_q;
    assign ans_fault = ans_fault_q;

    // Checks on the decoded behaviour.
    wire rsv_addr = (req_addr >= RSV_LO && req_addr <= RSV_HI) ||
                    req_addr == RSV_A || req_addr == RSV_B;

    a_bit_range_fault: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && req_valid && (is_bset || is_bclr) && req_addr > BIT_IO_MAX &&
        hw_flag_set == 8'h00
        |=> ans_fault && $stable(flag_view))
        else $error("bit operation above the low range was not refused");

    a_skip_bit_test: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && req_valid && is_sks && bit_ok
        |=> ans_valid && ans_skip == $past(sel_bit) && !ans_fault)
        else $error("skip decision does not follow the tested bit");

    a_flag_w1c_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && req_valid && is_io_wr && req_addr == FLAG_IO &&
        hw_flag_set == 8'h00
        |=> flag_view == ($past(flag_view) & ~$past(req_wdata)))
        else $error("flag register did not clear exactly the ones written");

    a_bitop_single_bit: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && req_valid && (is_bset || is_bclr) && req_addr == FLAG_IO &&
        hw_flag_set == 8'h00
        |=> ((flag_view ^ $past(flag_view)) & ~$past(bit_mask)) == 8'h00)
        else $error("bit operation changed a flag other than its own");

    a_io_window_limit: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && req_valid && (is_io_rd || is_io_wr) && req_addr > IO_MAX
        |=> ans_valid && ans_fault && ans_data == 8'h00)
        else $error("I/O access beyond the 64 locations was accepted");

    a_io_data_offset: assert property (
        @(posedge clk) disable iff (!rst_n)
        req_valid && is_io_op && io_ok
        |-> st.idx == req_addr + IO_DATA_OFS)
        else $error("I/O access not mapped at address plus offset");

    a_ext_mem_reach: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && req_valid && is_mem_op && req_addr >= EXT_LO &&
        req_addr <= EXT_HI
        |=> ans_valid && !ans_fault)
        else $error("load or store to the extended space was refused");

    a_rsv_read_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && req_valid && is_get && rsv_addr
        |=> ans_data == 8'h00 && !ans_fault)
        else $error("reserved location did not read as zero");

    // Answer timing, the clock enable, refusals, skip-if-clear, I/O reach, flag priority and reserved locations.
    a_answer_one_cycle: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce |=> ans_valid == $past(req_valid))
        else $error("answer did not follow its request by one cycle");

    a_ce_freeze_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        !ce
        |=> $stable({ans_valid, ans_data, ans_skip, ans_fault, flag_view}))
        else $error("state changed while the clock enable was low");

    a_fault_answer_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && req_valid && fault
        |=> ans_valid && ans_fault && ans_data == 8'h00 && !ans_skip)
        else $error("refused operation returned data or a skip");

    a_skip_clear_test: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && req_valid && is_skc && bit_ok
        |=> ans_valid && ans_skip == !$past(sel_bit) && !ans_fault)
        else $error("skip-if-clear decision does not follow the bit");

    a_flag_set_wins: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce |=> (flag_view & $past(hw_flag_set)) == $past(hw_flag_set))
        else $error("raised flag was lost to a clear in the same cycle");

    a_io_ext_unreached: assert property (
        @(posedge clk) disable iff (!rst_n)
        req_valid && is_io_op |-> st.idx < EXT_LO)
        else $error("I/O operation reached the extended space");

    a_rsv_store_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        req_valid && is_mem_op && rsv_addr |-> st.rdata == 8'h00)
        else $error("reserved location drove nonzero read data");

    a_rsv_write_ignored: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && req_valid && is_put && rsv_addr && hw_flag_set == 8'h00
        |=> ans_valid && !ans_fault && $stable(flag_view))
        else $error("write to a reserved location was refused or took effect");

    a_mem_low_fault: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && req_valid && is_mem_op && req_addr < IO_DATA_OFS
        |=> ans_valid && ans_fault)
        else $error("load or store below the I/O image was accepted");

endmodule // io_space_access_map

//--- src/io_store_if.sv
// Access channel between the address decoder and the register store.
`timescale 1ns/1ps
interface io_store_if;
    logic [7:0] idx;
    logic       wr;
    logic [7:0] wdata;
    logic [7:0] wmask;
    logic [7:0] rdata;

    modport ctrl  (output idx, output wr, output wdata, output wmask,
                   input rdata);
    modport store (input idx, input wr, input wdata, input wmask,
                   output rdata);
endinterface

//--- tb/core_model.sv
// Core-side model that issues one-cycle requests into the access map.
`timescale 1ns/1ps
module core_model
    import io_map_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Request
    output logic            req_valid,
    output op_t             req_op,
    output logic [7:0]      req_addr,
    output logic [2:0]      req_bit,
    output logic [7:0]      req_wdata
);
    initial begin
        req_valid = 1'b0;
        req_op    = OP_IO_READ;
        req_addr  = 8'h00;
        req_bit   = 3'h0;
        req_wdata = 8'h00;
    end

    // Holds one request for one edge; a caller may chain requests back to
    // back and ends a burst with idle. Reserved places are written only when
    // a caller asks for it on purpose.
    task automatic issue(input op_t o, input logic [7:0] a,
                         input logic [2:0] b, input logic [7:0] d);
        req_valid <= 1'b1;
        req_op    <= o;
        req_addr  <= a;
        req_bit   <= b;
        req_wdata <= d;
        @(posedge clk);
        #1;
    endtask

    task automatic idle;
        req_valid <= 1'b0;
        req_wdata <= ~req_wdata;
        @(posedge clk);
        #1;
    endtask
endmodule // core_model

//--- tb/testbench.sv
// Self-checking bench for the peripheral I/O space access map.
`timescale 1ns/1ps
module testbench
    import io_map_pkg::*;
;
    logic       clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
    logic       req_valid, ans_valid, ans_skip, ans_fault;
    op_t        req_op;
    logic [7:0] req_addr, req_wdata, ans_data, flag_view, v, w;
    logic [7:0] hw_flag_set = 8'h00;
    logic [2:0] req_bit;
    logic [9:0] exp_q[$];
    int         bad_count = 0, total_checks = 0, seed = 40;

    core_model core (.clk(clk), .req_valid(req_valid), .req_op(req_op),
        .req_addr(req_addr), .req_bit(req_bit), .req_wdata(req_wdata));
    io_space_access_map dut (.clk(clk), .rst_n(rst_n), .ce(ce),
        .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
        .req_bit(req_bit), .req_wdata(req_wdata), .ans_valid(ans_valid),
        .ans_data(ans_data), .ans_skip(ans_skip), .ans_fault(ans_fault),
        .hw_flag_set(hw_flag_set), .flag_view(flag_view));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [9:0] seen, input logic [9:0] want,
                         input string what);
        total_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h want %h",
                     $time, what, seen, want);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Expected answer is {fault, skip, data}.
    task automatic op(input op_t o, input logic [7:0] a, input logic [2:0] b,
                      input logic [7:0] d, input logic [9:0] e);
        exp_q.push_back(e);
        core.issue(o, a, b, d);
    endtask

    always @(negedge clk) begin
        if (ans_valid === 1'b1) begin
            if (exp_q.size() == 0)
                check(10'h3FF, 10'h000, "unexpected answer");
            else
                check({ans_fault, ans_skip, ans_data}, exp_q.pop_front(),
                      "answer");
        end
    end

    initial begin
        repeat (2000) @(posedge clk);
        bad_count++;
        complete_run();
    end

    initial begin
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        v = 8'($random(seed));
        w = 8'($random(seed));
        op(OP_IO_WRITE, 8'h05, 3'h0, v, 10'h000);
        op(OP_MEM_GET, 8'h25, 3'h0, w, {2'b00, v});
        for (int i = 0; i < 8; i++) begin
            op(OP_SKIP_SET, 8'h05, i[2:0], w, {1'b0, v[i], 8'h00});
            op(OP_SKIP_CLEAR, 8'h05, i[2:0], w, {1'b0, ~v[i], 8'h00});
        end
        $display("test done: window and skip");
        op(OP_IO_WRITE, 8'h1F, 3'h0, v, 10'h000);
        op(OP_BIT_SET, 8'h1F, 3'h0, w, 10'h000);
        op(OP_BIT_CLEAR, 8'h1F, 3'h7, w, 10'h000);
        op(OP_MEM_GET_DISPLACED, 8'h3F, 3'h0, w,
           {2'b00, (v | 8'h01) & 8'h7F});
        op(OP_BIT_SET, 8'h20, 3'h0, w, 10'h200);
        op(OP_SKIP_SET, 8'h20, 3'h0, w, 10'h200);
        op(OP_IO_READ, 8'h20, 3'h0, w, 10'h000);
        $display("test done: bit operations");
        hw_flag_set = 8'h03;
        core.idle();
        hw_flag_set = 8'h00;
        check({2'b00, flag_view}, 10'h003, "flag set");
        op(OP_BIT_SET, 8'h16, 3'h0, w, 10'h000);
        check({2'b00, flag_view}, 10'h002, "flag clear");
        op(OP_BIT_CLEAR, 8'h16, 3'h1, w, 10'h000);
        op(OP_IO_WRITE, 8'h16, 3'h0, 8'h00, 10'h000);
        op(OP_IO_READ, 8'h16, 3'h0, w, 10'h002);
        op(OP_MEM_PUT, 8'h36, 3'h0, 8'h02, 10'h000);
        op(OP_IO_READ, 8'h16, 3'h0, w, 10'h000);
        hw_flag_set = 8'h01;
        op(OP_BIT_SET, 8'h16, 3'h0, w, 10'h000);
        hw_flag_set = 8'h00;
        check({2'b00, flag_view}, 10'h001, "flag set wins");
        op(OP_IO_WRITE, 8'h16, 3'h0, 8'h01, 10'h000);
        op(OP_IO_READ, 8'h16, 3'h0, w, 10'h000);
        $display("test done: flags");
        op(OP_IO_READ, 8'h40, 3'h0, w, 10'h200);
        op(OP_IO_WRITE, 8'h60, 3'h0, v, 10'h200);
        op(OP_MEM_PUT_DISPLACED, 8'h60, 3'h0, v, 10'h000);
        op(OP_MEM_GET, 8'h60, 3'h0, w, {2'b00, v});
        core.idle();
        ce = 1'b0;
        hw_flag_set = 8'h04;
        core.issue(OP_MEM_PUT, 8'h60, 3'h0, ~v);
        core.idle();
        ce = 1'b1;
        hw_flag_set = 8'h00;
        check({2'b00, flag_view}, 10'h000, "flags frozen");
        op(OP_MEM_GET, 8'h60, 3'h0, w, {2'b00, v});
        op(OP_IO_WRITE, 8'h3F, 3'h0, w, 10'h000);
        op(OP_MEM_GET_DIRECT, 8'h5F, 3'h0, v, {2'b00, w});
        op(OP_MEM_GET, 8'h1F, 3'h0, w, 10'h200);
        op(op_t'(4'hF), 8'h05, 3'h0, w, 10'h200);
        op(OP_MEM_PUT, 8'h8C, 3'h0, v, 10'h000);
        op(OP_MEM_PUT_DIRECT, 8'hB7, 3'h0, w, 10'h000);
        op(OP_MEM_GET, 8'h8C, 3'h0, w, 10'h000);
        op(OP_MEM_GET_DISPLACED, 8'hB7, 3'h0, w, 10'h000);
        core.idle();
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge clk);
        if (exp_q.size() > 0)
            bad_count++;
        $display("test done: ranges and reserved");
        complete_run();
    end
endmodule // testbench
